/* File: twi_shortcut_irq.sv */
// Shortcut links and interrupt arming for the two-wire serial port.
// Assumes event pulses and transfer context come from the serial engine
// on aclk, and software reaches the registers over AXI4-Lite.
//
// Operation
// - Two link bits let each byte-edge event fire the pause task and/or the halt task.
// - Writing one to the halted field arms its interrupt and reading shows the armed state.
// - Writing one to the received-byte field arms that interrupt and reads back armed.
// - Writing one to the transmitted-byte field arms that interrupt and reads back armed.
// - Writing one to the error field arms that interrupt and reads back armed.
// - Writing one to the byte-edge field arms that interrupt and reads back armed.
// - Writing one to the paused field arms that interrupt and reads back armed.
// - The paused event comes only in a read transfer right after the ack, if pause was asked.
// - The pause request is judged per read transfer; none asked means no paused event.
// - The byte-edge event comes before each byte and drives both links.
`include "twi_irq_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module twi_shortcut_irq (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire twi_irq_pkg::events_s engine_events,
  input wire twi_irq_pkg::xfer_s xfer,
  input wire logic pause_task_sw,
  output twi_irq_pkg::tasks_s tasks,
  output logic paused_event,
  output logic irq
);
  import twi_irq_pkg::*;

  state_s st_r;
  state_s st_nxt;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    logic [`NUM_EV-1:0] ev;
    logic [`NUM_EV-1:0] clr;
    logic [31:0] rd;
    logic wr_go;
    logic edge_now;
    logic pause_req;
    ev = '0;
    clr = '0;
    rd = '0;
    wr_go = 1'b0;
    edge_now = 1'b0;
    pause_req = 1'b0;
    st_nxt = st_r;

    // Shortcut links
    edge_now = engine_events.byte_edge;
    st_nxt.tasks.pause = edge_now & st_r.links[`LINK_PAUSE_BIT];
    st_nxt.tasks.halt = edge_now & st_r.links[`LINK_HALT_BIT];

    // Pause request held for the current transfer only
    pause_req = st_r.pause_pend | pause_task_sw | st_nxt.tasks.pause;
    st_nxt.paused_evt = 1'b0;
    if (xfer.read_xfer && xfer.ack_done && pause_req) begin
      st_nxt.paused_evt = 1'b1;
      st_nxt.pause_pend = 1'b0;
    end else if (xfer.xfer_end) begin
      st_nxt.pause_pend = 1'b0;
    end else begin
      st_nxt.pause_pend = pause_req;
    end

    ev[`EV_HALTED_BIT] = engine_events.halted;
    ev[`EV_RX_BIT] = engine_events.rx_byte_ready;
    ev[`EV_TX_BIT] = engine_events.tx_byte_done;
    ev[`EV_ERROR_BIT] = engine_events.error;
    ev[`EV_EDGE_BIT] = engine_events.byte_edge;
    // Paused flag only from own qualified pulse; raw input ignored
    ev[`EV_PAUSED_BIT] = st_r.paused_evt;

    // Write channel
    if (s_axi_awvalid && st_r.awready) begin
      st_nxt.aw_have = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_r.wready) begin
      st_nxt.w_have = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    case (st_r.wr_state)
      bus_idle: begin
        if (st_r.aw_have && st_r.w_have) begin
          wr_go = 1'b1;
          st_nxt.aw_have = 1'b0;
          st_nxt.w_have = 1'b0;
          st_nxt.wr_state = bus_resp;
          st_nxt.bresp = `RESP_OKAY;
        end
      end
      bus_resp: begin
        if (s_axi_bready) begin
          st_nxt.wr_state = bus_idle;
        end
      end
      default: begin
        st_nxt.wr_state = bus_idle;
      end
    endcase

    // Only byte lane 0 holds fields
    if (wr_go) begin
      case (st_r.aw_addr & ~12'h003)
        `OFS_EVENT_TASK_LINKS: begin
          if (st_r.wstrb[0]) begin
            st_nxt.links = st_r.wdata[`NUM_LINKS-1:0];
          end
        end
        `OFS_IRQ_ENABLE_SET: begin
          if (st_r.wstrb[0]) begin
            // Set-only: zeros leave fields alone
            st_nxt.armed = st_r.armed | st_r.wdata[`NUM_EV-1:0];
          end
        end
        `OFS_IRQ_STATUS: begin
          if (st_r.wstrb[0]) begin
            clr = st_r.wdata[`NUM_EV-1:0];
          end
        end
        default: begin
          st_nxt.bresp = `RESP_SLVERR;
        end
      endcase
    end
    // New event beats a clear in the same cycle
    st_nxt.status = (st_r.status & ~clr) | ev;

    st_nxt.awready = !st_nxt.aw_have && st_nxt.wr_state == bus_idle;
    st_nxt.wready = !st_nxt.w_have && st_nxt.wr_state == bus_idle;

    // Read channel
    case (st_r.rd_state)
      bus_idle: begin
        if (s_axi_arvalid && st_r.arready) begin
          st_nxt.rd_state = bus_resp;
          st_nxt.rresp = `RESP_OKAY;
          case (s_axi_araddr & ~12'h003)
            `OFS_EVENT_TASK_LINKS: rd[`NUM_LINKS-1:0] = st_r.links;
            // Read-back of armed state
            `OFS_IRQ_ENABLE_SET: rd[`NUM_EV-1:0] = st_r.armed;
            `OFS_IRQ_STATUS: rd[`NUM_EV-1:0] = st_r.status;
            default: st_nxt.rresp = `RESP_SLVERR;
          endcase
          st_nxt.rdata = rd;
        end
      end
      bus_resp: begin
        if (s_axi_rready) begin
          st_nxt.rd_state = bus_idle;
        end
      end
      default: begin
        st_nxt.rd_state = bus_idle;
      end
    endcase
    st_nxt.arready = st_nxt.rd_state == bus_idle;

    st_nxt.irq = |(st_nxt.status & st_nxt.armed);
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.links <= `RST_LINKS;
      st_r.armed <= `RST_ARMED;
      st_r.status <= `RST_STATUS;
      st_r.wr_state <= bus_idle;
      st_r.rd_state <= bus_idle;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_awready = st_r.awready;
  assign s_axi_wready = st_r.wready;
  assign s_axi_bvalid = (st_r.wr_state == bus_resp);
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rvalid = (st_r.rd_state == bus_resp);
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign tasks = st_r.tasks;
  assign paused_event = st_r.paused_evt;
  assign irq = st_r.irq;

endmodule
`default_nettype wire

/* File: twi_irq_consts.svh */
// Offsets, field positions and reset values of the shortcut and interrupt block.
// Assumes inclusion by bare name from the package and the design file.
`ifndef TWI_IRQ_CONSTS_SVH
`define TWI_IRQ_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_EVENT_TASK_LINKS 12'h200
`define OFS_IRQ_ENABLE_SET 12'h304
`define OFS_IRQ_STATUS 12'h400
`define ADDR_W 12

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LINK_PAUSE_BIT 0
`define LINK_HALT_BIT 1
`define EV_HALTED_BIT 0
`define EV_RX_BIT 1
`define EV_TX_BIT 2
`define EV_ERROR_BIT 3
`define EV_EDGE_BIT 4
`define EV_PAUSED_BIT 5
`define NUM_EV 6
`define NUM_LINKS 2

// ----------------------------------------
// Reset values and responses
// ----------------------------------------
`define RST_LINKS 2'h0
`define RST_ARMED 6'h00
`define RST_STATUS 6'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: twi_irq_pkg.sv */
// Types shared by the shortcut and interrupt block and its users.
// Assumes the constants header sits in the same folder.
`include "twi_irq_consts.svh"

package twi_irq_pkg;

  // Event pulses from the serial engine, one cycle each
  typedef struct packed {
    logic paused;
    logic byte_edge;
    logic error;
    logic tx_byte_done;
    logic rx_byte_ready;
    logic halted;
  } events_s;

  // Transfer context from the serial engine
  typedef struct packed {
    logic read_xfer;
    logic ack_done;
    logic xfer_end;
  } xfer_s;

  // Task triggers towards the serial engine
  typedef struct packed {
    logic halt;
    logic pause;
  } tasks_s;

  typedef enum logic [0:0] {
    bus_idle,
    bus_resp
  } bus_state_e;

  typedef struct packed {
    logic [`NUM_LINKS-1:0] links;
    logic [`NUM_EV-1:0] armed;
    logic [`NUM_EV-1:0] status;
    logic pause_pend;
    tasks_s tasks;
    logic paused_evt;
    logic irq;
    bus_state_e wr_state;
    logic aw_have;
    logic w_have;
    logic [`ADDR_W-1:0] aw_addr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic [1:0] bresp;
    bus_state_e rd_state;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_s;

endpackage

/* File: twi_shortcut_irq_properties.sv */
// Concurrent checks on the shortcut and interrupt block.
// Assumes a bind onto twi_shortcut_irq; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module twi_shortcut_irq_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire twi_irq_pkg::events_s engine_events,
  input wire twi_irq_pkg::xfer_s xfer,
  input wire twi_irq_pkg::tasks_s tasks,
  input wire logic paused_event,
  input wire logic irq
);
  import twi_irq_pkg::*;
  // ----
  // Checks
  // ----
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence ar_taken; s_axi_arvalid && s_axi_arready; endsequence
  sequence r_done; s_axi_rvalid && s_axi_rready; endsequence
  sequence b_done; s_axi_bvalid && s_axi_bready; endsequence
  a_link_pause: assert property (tasks.pause |-> $past(engine_events.byte_edge))
    else $error("pause task without byte edge");
  a_link_halt: assert property (tasks.halt |-> $past(engine_events.byte_edge))
    else $error("halt task without byte edge");
  a_paused_cause: assert property (paused_event |-> $past(xfer.read_xfer && xfer.ack_done))
    else $error("paused event outside read ack");
  a_paused_pulse: assert property (paused_event |=> !paused_event)
    else $error("paused event longer than one cycle");
  a_read_answer: assert property (ar_taken |=> s_axi_rvalid)
    else $error("read answer late");
  a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  a_read_drop: assert property (r_done |=> !s_axi_rvalid)
    else $error("read answer not released");
  a_write_drop: assert property (b_done |=> !s_axi_bvalid)
    else $error("write answer not released");
  // Arming shows as bvalid rising on the commit edge
  a_irq_cause: assert property ($rose(irq) |->
    $past(|engine_events[4:0]) || $past(paused_event) || s_axi_bvalid)
    else $error("interrupt rose without cause");
endmodule

bind twi_shortcut_irq twi_shortcut_irq_properties i_props (.aclk, .aresetn, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .engine_events, .xfer, .tasks, .paused_event, .irq);
`default_nettype wire

/* File: twi_shortcut_irq_test.sv */
// Self-checking bench for the shortcut and interrupt block.
// Assumes package, design and checker files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module twi_shortcut_irq_test;
  import twi_irq_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, pause_task_sw, paused_event, irq;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, mask, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  events_s engine_events;
  xfer_s xfer;
  tasks_s tasks;
  logic [33:0] q[$];
  int n_fail, compares, cyc;
  twi_shortcut_irq i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .engine_events, .xfer, .pause_task_sw, .tasks, .paused_event,
    .irq);
  // ----
  // Tasks
  // ----
  initial begin
    aclk = 1'h0;
    forever #4 aclk = ~aclk;
  end
  task automatic check(input logic [33:0] s, input logic [33:0] e);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("Error %0t: got %h want %h", $time, s, e);
    end
  endtask
  task close_out;
    $display("Checks %0d, errors %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Ready read pre-edge, so each item drops on its own handshake
  task wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    check(s_axi_bresp, r);
    s_axi_bready <= 1'h0;
  endtask
  task rd(input logic [11:0] a, input logic [33:0] e);
    @(posedge aclk);
    q.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
  endtask
  task pulse(input logic [5:0] e, input logic [2:0] x, input logic p);
    @(posedge aclk);
    engine_events <= e;
    xfer <= x;
    pause_task_sw <= p;
    @(posedge aclk);
    engine_events <= 6'h00;
    xfer <= 3'h0;
    pause_task_sw <= 1'h0;
    @(posedge aclk);
  endtask
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, q.pop_front());
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      close_out;
    end
  end
  // ----
  // Scenarios
  // ----
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, pause_task_sw} = 3'h0;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    engine_events = 6'h00;
    xfer = 3'h0;
    void'($urandom(71948));
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    rd(12'h200, 34'h0);
    rd(12'h304, 34'h0);
    pulse(6'h1f, 3'h0, 1'h0);
    check(irq, 1'h0);
    check(tasks, 2'h0);
    mask = 32'h0;
    for (int i = 0; i < 6; i++) begin
      mask[i] = 1'h1;
      wr(12'h304, 32'h1 << i, 2'h0);
      rd(12'h304, {2'h0, mask});
    end
    check(irq, 1'h1);
    wr(12'h304, 32'h0, 2'h0);
    rd(12'h304, 34'h3f);
    wr(12'h400, 32'h3f, 2'h0);
    check(irq, 1'h0);
    wr(12'h100, 32'h3f, 2'h2);
    rd(12'h100, {2'h2, 32'h0});
    for (int l = 0; l < 4; l++) begin
      d = $urandom;
      wr(12'h200, {d[31:2], l[1:0]}, 2'h0);
      rd(12'h200, l);
      pulse(6'h10, 3'h0, 1'h0);
      check(tasks, l);
      pulse(6'h00, 3'h6, 1'h0);
      check(paused_event, l & 1);
      pulse(6'h00, 3'h1, 1'h0);
    end
    pulse(6'h00, 3'h0, 1'h1);
    pulse(6'h00, 3'h2, 1'h0);
    check(paused_event, 1'h0);
    pulse(6'h00, 3'h6, 1'h0);
    check(paused_event, 1'h1);
    pulse(6'h00, 3'h6, 1'h0);
    check(paused_event, 1'h0);
    // Byte edges and qualified pause pulses left flags since the clear
    rd(12'h400, 34'h30);
    check(irq, 1'h1);
    // Reset in mid-run drops arming, links and flags
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    check(irq, 1'h0);
    rd(12'h304, 34'h0);
    rd(12'h200, 34'h0);
    // Raw paused input must not raise the flag or the interrupt
    wr(12'h304, 32'h3f, 2'h0);
    pulse(6'h20, 3'h0, 1'h0);
    check(paused_event, 1'h0);
    check(irq, 1'h0);
    rd(12'h400, 34'h0);
    repeat (2) @(posedge aclk);
    close_out;
  end
endmodule
`default_nettype wire
